// File: src/spsr_data_buf.sv
// Purpose: small holding buffer for the received data word
// Assumes: one write port, registered read
// Notes:   index 1 holds the received word, index 0 is spare
`timescale 1ns/1ps
module spsr_data_buf #(
   parameter int W = 9
) (
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic         we_i,
   input  wire logic         waddr_i,
   input  wire logic [W-1:0] wdata_i,
   input  wire logic         raddr_i,
   output logic      [W-1:0] rdata_o
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic [W-1:0]      rd;
   } spsr_buf_st_t;
   spsr_buf_st_t st_reg;
   spsr_buf_st_t st_next;
   always_comb begin
      st_next = st_reg;
      if (we_i) begin
         st_next.mem[waddr_i] = wdata_i;
      end
      st_next.rd = st_reg.mem[raddr_i];
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign rdata_o = st_reg.rd;
endmodule : spsr_data_buf

// File: src/spsr_pkg.sv
// Purpose: constants for the serial port status and register block
// Assumes: 32-bit register port, byte offsets
// Notes:   field positions follow the register map
package spsr_pkg;
   localparam logic [7:0]  OFF_STATUS  = 8'h00;
   localparam logic [7:0]  OFF_DATA    = 8'h04;
   localparam logic [7:0]  OFF_BAUD    = 8'h08;
   localparam logic [7:0]  OFF_CTRL1   = 8'h0c;
   localparam logic [7:0]  OFF_CTRL2   = 8'h10;
   localparam logic [7:0]  OFF_CTRL3   = 8'h14;
   localparam logic [7:0]  OFF_GTP     = 8'h18;
   localparam logic [7:0]  OFF_IRQ_ST  = 8'h1c;
   localparam logic [7:0]  OFF_IRQ_MSK = 8'h20;
   localparam int STS_RXDR  = 5;
   localparam int STS_TXC   = 6;
   localparam int STS_TXBE  = 7;
   localparam int STS_BRK   = 8;
   localparam int STS_FLOW  = 9;
   localparam logic [31:0] STATUS_RST = 32'h0000_00c0;
   localparam int C1_RXIE   = 5;
   localparam int C1_TXCIE  = 6;
   localparam int C1_TXBEIE = 7;
   localparam int C2_BRKIE  = 6;
   localparam int C2_LIN    = 14;
   localparam int C3_FLOWEN = 9;
   localparam int C3_FLOWIE = 10;
   localparam logic [31:0] CTRL1_MASK = 32'h0000_3fff;
   localparam logic [31:0] CTRL2_MASK = 32'h0000_7f6f;
   localparam logic [31:0] CTRL3_MASK = 32'h0000_07ff;
   localparam logic [31:0] BAUD_MASK  = 32'h0000_ffff;
   localparam logic [31:0] GTP_MASK   = 32'h0000_ffff;
   localparam logic [31:0] DATA_MASK  = 32'h0000_01ff;
   localparam int EVT_W = 5;
endpackage : spsr_pkg

// File: src/spsr_top.sv
// Purpose: register map and status flags of a serial port
// Assumes: engines deliver one-cycle event pulses in the clk_i domain
// Notes on behaviour
// - with flow monitoring on, a level change of clear_to_send_input_n sets status bit 9.
// - the interrupt is raised while the flow change flag and its enable are both set.
// - with LIN mode on, a detected break sets status bit 8.
// - the interrupt is raised while the break flag and its enable are both set.
// - flow and break flags stay set until software writes zero to them.
// - the status register reads 0x000000c0 after reset.
// - buffer-empty sets on reset or move to shifter and clears on a data write.
// - with buffer-empty set, complete sets at frame end; software clears it.
// - receive-ready sets on a receive move and clears on zero write or data read.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module spsr_top #(
   parameter int DATA_W = 9
) (
   input  wire logic              clk_i,
   input  wire logic              nrst_i,
   input  wire logic [7:0]        addr_i,
   input  wire logic [31:0]       wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [31:0]       rdata_o,
   input  wire logic              clear_to_send_input_n_i,
   input  wire logic              break_seen_i,
   input  wire logic              tx_load_i,
   input  wire logic              tx_frame_done_i,
   input  wire logic              rx_move_i,
   input  wire logic [DATA_W-1:0] rx_data_i,
   output logic      [DATA_W-1:0] tx_data_o,
   output logic                   tx_data_valid_o,
   output logic      [15:0]       baud_div_o,
   output logic      [31:0]       ctrl1_o,
   output logic      [31:0]       ctrl2_o,
   output logic      [31:0]       ctrl3_o,
   output logic      [15:0]       guard_prescale_o,
   output logic                   irq_o
);
   localparam int EVT_W_L = spsr_pkg::EVT_W;

   typedef enum logic [1:0] {
      SPSR_RD_NONE = 2'b00,
      SPSR_RD_REG  = 2'b01,
      SPSR_RD_DATA = 2'b10
   } spsr_rd_t;

   typedef struct packed {
      logic                   transmit_buffer_empty_flag;
      logic                   transmission_complete_flag;
      logic                   receive_data_ready_flag;
      logic                   break_detected_flag;
      logic                   flow_change_flag;
      logic                   cts_seen;
      logic                   cts_seen_ok;
      logic [31:0]            ctrl1;
      logic [31:0]            ctrl2;
      logic [31:0]            ctrl3;
      logic [15:0]            baud;
      logic [15:0]            gtp;
      logic [EVT_W_L-1:0]     evt_st;
      logic [EVT_W_L-1:0]     evt_msk;
      logic                   tx_pend;
      logic [DATA_W-1:0]      tx_word;
      spsr_rd_t               rd_kind;
      logic [31:0]            rd_word;
      logic                   irq;
   } spsr_st_t;

   spsr_st_t          st_reg;
   spsr_st_t          st_next;
   logic [DATA_W-1:0] buf_rdata;
   logic              buf_we;
   logic              buf_waddr;
   logic [DATA_W-1:0] buf_wdata;
   logic [31:0]       status_word;
   logic [EVT_W_L-1:0] evt_now;
   logic              data_wr;

   // a strobed write or read hit at the given offset
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic s);
      hit = s && (a == off);
   endfunction : hit

   assign data_wr   = hit(addr_i, spsr_pkg::OFF_DATA, wr_i);
   // receive slot only; transmit word is held apart so a move never collides
   assign buf_we    = rx_move_i;
   assign buf_waddr = 1'b1;
   assign buf_wdata = rx_data_i;

   spsr_data_buf #(
      .W       (DATA_W)
   ) u_buf (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .we_i    (buf_we),
      .waddr_i (buf_waddr),
      .wdata_i (buf_wdata),
      .raddr_i (1'b1),
      .rdata_o (buf_rdata)
   );

   always_comb begin
      status_word                      = '0;
      status_word[spsr_pkg::STS_FLOW]  = st_reg.flow_change_flag;
      status_word[spsr_pkg::STS_BRK]   = st_reg.break_detected_flag;
      status_word[spsr_pkg::STS_TXBE]  = st_reg.transmit_buffer_empty_flag;
      status_word[spsr_pkg::STS_TXC]   = st_reg.transmission_complete_flag;
      status_word[spsr_pkg::STS_RXDR]  = st_reg.receive_data_ready_flag;
   end

   always_comb begin
      logic flow_en;
      logic lin_en;
      logic sts_wr;
      logic rd_data;
      flow_en = st_reg.ctrl3[spsr_pkg::C3_FLOWEN];
      lin_en  = st_reg.ctrl2[spsr_pkg::C2_LIN];
      sts_wr  = hit(addr_i, spsr_pkg::OFF_STATUS, wr_i);
      rd_data = hit(addr_i, spsr_pkg::OFF_DATA, rd_i);
      st_next = st_reg;

      st_next.cts_seen    = clear_to_send_input_n_i;
      st_next.cts_seen_ok = 1'b1;
      evt_now    = '0;
      evt_now[0] = flow_en && st_reg.cts_seen_ok &&
                   (clear_to_send_input_n_i != st_reg.cts_seen);
      evt_now[1] = lin_en && break_seen_i;
      evt_now[2] = tx_load_i && st_reg.tx_pend;
      evt_now[3] = tx_frame_done_i && st_reg.transmit_buffer_empty_flag;
      evt_now[4] = rx_move_i;

      if (sts_wr && !wdata_i[spsr_pkg::STS_FLOW]) begin
         st_next.flow_change_flag = 1'b0;
      end
      if (sts_wr && !wdata_i[spsr_pkg::STS_BRK]) begin
         st_next.break_detected_flag = 1'b0;
      end
      if (sts_wr && !wdata_i[spsr_pkg::STS_TXC]) begin
         st_next.transmission_complete_flag = 1'b0;
      end
      // clear on zero write or data read
      if ((sts_wr && !wdata_i[spsr_pkg::STS_RXDR]) || rd_data) begin
         st_next.receive_data_ready_flag = 1'b0;
      end
      if (evt_now[0]) begin
         st_next.flow_change_flag = 1'b1;
      end
      if (evt_now[1]) begin
         st_next.break_detected_flag = 1'b1;
      end
      if (evt_now[3]) begin
         st_next.transmission_complete_flag = 1'b1;
      end
      if (evt_now[4]) begin
         st_next.receive_data_ready_flag = 1'b1;
      end

      if (data_wr) begin
         st_next.transmit_buffer_empty_flag = 1'b0;
         st_next.tx_pend                    = 1'b1;
         st_next.tx_word                    = wdata_i[DATA_W-1:0];
      end else if (evt_now[2]) begin
         st_next.transmit_buffer_empty_flag = 1'b1;
         st_next.tx_pend                    = 1'b0;
      end

      if (hit(addr_i, spsr_pkg::OFF_BAUD, wr_i)) begin
         st_next.baud = wdata_i[15:0] & spsr_pkg::BAUD_MASK[15:0];
      end else if (hit(addr_i, spsr_pkg::OFF_CTRL1, wr_i)) begin
         st_next.ctrl1 = wdata_i & spsr_pkg::CTRL1_MASK;
      end else if (hit(addr_i, spsr_pkg::OFF_CTRL2, wr_i)) begin
         st_next.ctrl2 = wdata_i & spsr_pkg::CTRL2_MASK;
      end else if (hit(addr_i, spsr_pkg::OFF_CTRL3, wr_i)) begin
         st_next.ctrl3 = wdata_i & spsr_pkg::CTRL3_MASK;
      end else if (hit(addr_i, spsr_pkg::OFF_GTP, wr_i)) begin
         st_next.gtp = wdata_i[15:0] & spsr_pkg::GTP_MASK[15:0];
      end else if (hit(addr_i, spsr_pkg::OFF_IRQ_MSK, wr_i)) begin
         st_next.evt_msk = wdata_i[EVT_W_L-1:0];
      end

      // sticky event log, write one clears, set wins
      if (hit(addr_i, spsr_pkg::OFF_IRQ_ST, wr_i)) begin
         st_next.evt_st = st_reg.evt_st & ~wdata_i[EVT_W_L-1:0];
      end
      st_next.evt_st = st_next.evt_st | evt_now;

      st_next.irq = (st_next.flow_change_flag && st_next.ctrl3[spsr_pkg::C3_FLOWIE]) ||
                    (st_next.break_detected_flag && st_next.ctrl2[spsr_pkg::C2_BRKIE]) ||
                    (st_next.transmit_buffer_empty_flag &&
                     st_next.ctrl1[spsr_pkg::C1_TXBEIE]) ||
                    (st_next.transmission_complete_flag &&
                     st_next.ctrl1[spsr_pkg::C1_TXCIE]) ||
                    (st_next.receive_data_ready_flag && st_next.ctrl1[spsr_pkg::C1_RXIE]) ||
                    |(st_next.evt_st & st_next.evt_msk);

      // status read has no side effect
      st_next.rd_kind = SPSR_RD_NONE;
      st_next.rd_word = '0;
      if (rd_i) begin
         st_next.rd_kind = SPSR_RD_REG;
         if (addr_i == spsr_pkg::OFF_STATUS) begin
            st_next.rd_word = status_word;
         end else if (addr_i == spsr_pkg::OFF_DATA) begin
            st_next.rd_kind = SPSR_RD_DATA;
         end else if (addr_i == spsr_pkg::OFF_BAUD) begin
            st_next.rd_word = {16'h0000, st_reg.baud};
         end else if (addr_i == spsr_pkg::OFF_CTRL1) begin
            st_next.rd_word = st_reg.ctrl1;
         end else if (addr_i == spsr_pkg::OFF_CTRL2) begin
            st_next.rd_word = st_reg.ctrl2;
         end else if (addr_i == spsr_pkg::OFF_CTRL3) begin
            st_next.rd_word = st_reg.ctrl3;
         end else if (addr_i == spsr_pkg::OFF_GTP) begin
            st_next.rd_word = {16'h0000, st_reg.gtp};
         end else if (addr_i == spsr_pkg::OFF_IRQ_ST) begin
            st_next.rd_word = {{(32-EVT_W_L){1'b0}}, st_reg.evt_st};
         end else if (addr_i == spsr_pkg::OFF_IRQ_MSK) begin
            st_next.rd_word = {{(32-EVT_W_L){1'b0}}, st_reg.evt_msk};
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg                            <= '0;
         st_reg.transmit_buffer_empty_flag <= spsr_pkg::STATUS_RST[spsr_pkg::STS_TXBE];
         st_reg.transmission_complete_flag <= spsr_pkg::STATUS_RST[spsr_pkg::STS_TXC];
      end else begin
         st_reg <= st_next;
      end
   end

   // data read word comes from the buffer register one cycle late
   assign rdata_o          = (st_reg.rd_kind == SPSR_RD_DATA) ?
                             {{(32-DATA_W){1'b0}}, buf_rdata} : st_reg.rd_word;
   assign tx_data_o        = st_reg.tx_word;
   assign tx_data_valid_o  = st_reg.tx_pend;
   assign baud_div_o       = st_reg.baud;
   assign ctrl1_o          = st_reg.ctrl1;
   assign ctrl2_o          = st_reg.ctrl2;
   assign ctrl3_o          = st_reg.ctrl3;
   assign guard_prescale_o = st_reg.gtp;
   assign irq_o            = st_reg.irq;
endmodule : spsr_top

// File: test/spsr_top_asserts.sv
// Purpose: port-level assertions for the serial port status block
// Assumes: registered read data and irq, flags update one cycle after cause
// Notes:   bound to every spsr_top instance
`timescale 1ns/1ps
module spsr_top_asserts (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   input  wire logic [31:0] rdata_o,
   input  wire logic        clear_to_send_input_n_i,
   input  wire logic        break_seen_i,
   input  wire logic        tx_load_i,
   input  wire logic        tx_data_valid_o,
   input  wire logic [15:0] baud_div_o,
   input  wire logic [31:0] ctrl2_o,
   input  wire logic [31:0] ctrl3_o,
   input  wire logic        irq_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   sequence s_flow_edge;
      $past(nrst_i) && $changed(clear_to_send_input_n_i) && ctrl3_o[10:9] == 2'b11;
   endsequence
   sequence s_quiet;
      !wr_i && !rd_i && !$past(wr_i) && !$past(rd_i);
   endsequence
   a_flow_irq_raise: assert property (s_flow_edge |=> irq_o)
      else $error("irq missing after flow change");
   a_break_irq_raise: assert property (break_seen_i && ctrl2_o[14] && ctrl2_o[6] |=> irq_o)
      else $error("irq missing after break");
   a_irq_sticky_hold: assert property (irq_o ##0 s_quiet |=> irq_o)
      else $error("irq dropped without software access");
   a_data_write_pend: assert property (wr_i && addr_i == spsr_pkg::OFF_DATA |=> tx_data_valid_o)
      else $error("data write did not mark word pending");
   a_load_empties_buf: assert property (tx_data_valid_o && tx_load_i && !wr_i |=> !tx_data_valid_o)
      else $error("load did not empty transmit buffer");
   a_read_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data not zero without read");
   a_unmapped_read: assert property (rd_i && addr_i >= 8'h24 |=> rdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_baud_copy: assert property (wr_i && addr_i == spsr_pkg::OFF_BAUD |=>
      baud_div_o == $past(wdata_i[15:0]))
      else $error("baud output does not follow write");
   a_ctrl3_copy: assert property (wr_i && addr_i == spsr_pkg::OFF_CTRL3 |=>
      ctrl3_o == ($past(wdata_i) & spsr_pkg::CTRL3_MASK))
      else $error("ctrl3 output does not follow write");
endmodule : spsr_top_asserts

bind spsr_top spsr_top_asserts spsr_top_asserts_inst (
   .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .clear_to_send_input_n_i(clear_to_send_input_n_i),
   .break_seen_i(break_seen_i), .tx_load_i(tx_load_i), .tx_data_valid_o(tx_data_valid_o),
   .baud_div_o(baud_div_o), .ctrl2_o(ctrl2_o), .ctrl3_o(ctrl3_o), .irq_o(irq_o));

// File: test/testbench.sv
// Purpose: self-checking bench for the serial port status block
// Assumes: bench stands in for engines and software
// Notes:   status model kept beside the design, compared at each sts_chk status read
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
   logic        clk_i   = 1'b0;
   logic        nrst_i  = 1'b0;
   logic [7:0]  addr_i  = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic        wr_i    = 1'b0;
   logic        rd_i    = 1'b0;
   logic        cts_n   = 1'b1;
   logic [3:0]  ev      = 4'h0;
   logic [8:0]  rx_data = 9'h000;
   logic [31:0] rdata_o;
   logic [8:0]  tx_data_o;
   logic        tx_data_valid_o;
   logic [15:0] baud_div_o;
   logic [31:0] ctrl1_o;
   logic [31:0] ctrl2_o;
   logic [15:0] guard_prescale_o;
   logic        irq_o;
   logic [31:0] m_sts   = spsr_pkg::STATUS_RST;
   logic [31:0] m_c2    = 32'h0;
   logic [31:0] m_c3    = 32'h0;
   logic        m_pend  = 1'b0;
   logic [31:0] rd_val;
   logic [31:0] lfsr    = 32'd67718;
   int          bad_count   = 0;
   int          comparisons = 0;
   always #20 clk_i = ~clk_i;
   spsr_top spsr_top_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .clear_to_send_input_n_i(cts_n),
      .break_seen_i(ev[0]), .tx_load_i(ev[1]), .tx_frame_done_i(ev[2]), .rx_move_i(ev[3]),
      .rx_data_i(rx_data), .tx_data_o(tx_data_o), .tx_data_valid_o(tx_data_valid_o),
      .baud_div_o(baud_div_o), .ctrl1_o(ctrl1_o), .ctrl2_o(ctrl2_o), .ctrl3_o(),
      .guard_prescale_o(guard_prescale_o),
      .irq_o(irq_o));
   function automatic logic [31:0] next_rnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rnd
   task automatic end_of_test;
      $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
      #1;
      if (a == spsr_pkg::OFF_STATUS) m_sts = m_sts & (d | ~32'h0000_0360);
      if (a == spsr_pkg::OFF_DATA) {m_sts[7], m_pend} = 2'b01;
      if (a == spsr_pkg::OFF_CTRL2) m_c2 = d;
      if (a == spsr_pkg::OFF_CTRL3) m_c3 = d;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1;
      rd_val = rdata_o;
      if (a == spsr_pkg::OFF_DATA) m_sts[5] = 1'b0;
   endtask : rd
   task automatic sts_chk;
      rd(spsr_pkg::OFF_STATUS);
      `CHK(rd_val, m_sts)
   endtask : sts_chk
   // index 0 break, 1 load, 2 frame done, 3 receive move, 4 clear-to-send flip
   task automatic event_in(input int i);
      @(posedge clk_i);
      if (i == 4) cts_n <= ~cts_n;
      else ev[i] <= 1'b1;
      @(posedge clk_i);
      ev <= 4'h0;
      @(posedge clk_i);
      #1;
      if (i == 0 && m_c2[14]) m_sts[8] = 1'b1;
      if (i == 1 && m_pend) {m_sts[7], m_pend} = 2'b10;
      if (i == 2 && m_sts[7]) m_sts[6] = 1'b1;
      if (i == 3) m_sts[5] = 1'b1;
      if (i == 4 && m_c3[9]) m_sts[9] = 1'b1;
   endtask : event_in
   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      end_of_test;
   end
   initial begin
      repeat (10) @(posedge clk_i);
      nrst_i <= 1'b1;
      sts_chk;
      rd(8'h40);
      `CHK(rd_val, 32'h0)
      event_in(4);
      event_in(0);
      sts_chk;
      wr(spsr_pkg::OFF_CTRL3, 32'h0000_0600);
      rd(spsr_pkg::OFF_CTRL3);
      `CHK(rd_val, 32'h0000_0600)
      event_in(4);
      `CHK(irq_o, 1'b1)
      sts_chk;
      wr(spsr_pkg::OFF_STATUS, 32'h0000_03ff);
      rd(spsr_pkg::OFF_STATUS);
      sts_chk;
      repeat (20) @(posedge clk_i);
      sts_chk;
      wr(spsr_pkg::OFF_STATUS, 32'h0000_01ff);
      sts_chk;
      wr(spsr_pkg::OFF_CTRL2, 32'h0000_4040);
      `CHK(ctrl2_o, 32'h0000_4040)
      event_in(0);
      `CHK(irq_o, 1'b1)
      sts_chk;
      wr(spsr_pkg::OFF_STATUS, 32'h0000_02bf);
      sts_chk;
      wr(spsr_pkg::OFF_DATA, 32'h0000_0155);
      `CHK(tx_data_valid_o, 1'b1)
      `CHK(tx_data_o, 9'h155)
      event_in(2);
      sts_chk;
      event_in(1);
      sts_chk;
      event_in(2);
      sts_chk;
      // event log: flow, break, load and frame done seen so far
      rd(spsr_pkg::OFF_IRQ_ST);
      `CHK(rd_val, 32'h0000_000f)
      wr(spsr_pkg::OFF_IRQ_ST, 32'h0000_0003);
      rd(spsr_pkg::OFF_IRQ_ST);
      `CHK(rd_val, 32'h0000_000c)
      wr(spsr_pkg::OFF_IRQ_MSK, 32'h0000_0008);
      `CHK(irq_o, 1'b1)
      wr(spsr_pkg::OFF_IRQ_MSK, 32'h0000_0000);
      `CHK(irq_o, 1'b0)
      wr(spsr_pkg::OFF_CTRL1, 32'h0000_0020);
      `CHK(ctrl1_o, 32'h0000_0020)
      for (int k = 0; k < 8; k++) begin
         lfsr = next_rnd(lfsr);
         rx_data <= lfsr[8:0];
         wr(spsr_pkg::OFF_BAUD, lfsr);
         `CHK(baud_div_o, lfsr[15:0])
         wr(spsr_pkg::OFF_GTP, ~lfsr);
         `CHK(guard_prescale_o, ~lfsr[15:0])
         event_in(3);
         `CHK(irq_o, 1'b1)
         sts_chk;
         if (k[0]) begin
            rd(spsr_pkg::OFF_DATA);
            `CHK(rd_val[8:0], lfsr[8:0])
         end else begin
            wr(spsr_pkg::OFF_STATUS, 32'h0000_03df);
         end
         sts_chk;
         `CHK(irq_o, 1'b0)
      end
      // second reset in mid-run
      @(posedge clk_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      nrst_i <= 1'b1;
      m_sts = spsr_pkg::STATUS_RST;
      m_c2  = 32'h0;
      m_c3  = 32'h0;
      m_pend = 1'b0;
      `CHK(baud_div_o, 16'h0000)
      `CHK(tx_data_valid_o, 1'b0)
      sts_chk;
      end_of_test;
   end
endmodule : testbench
